// [dv/second_resolver_channel_tb.sv]
/*
  Self-checking bench of the second resolver channel over AHB-Lite.
  Assumes the resolver model on the converter pins and a short sample period.
*/
`timescale 1ns/1ps
`include "src_consts.svh"
module second_resolver_channel_tb;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, exc_max = 0, exc_min = 0, exc_ref = 0;
  logic [31:0] haddr = 0, hwdata = 0, rdata;
  logic [1:0] htrans = 0;
  logic [15:0] amp = 16'h3e80, sinv, cosv;
  logic [31:0] hrdata;
  logic hreadyout, adc_start, exc_ref_o, exc_en, sync_en, irq;
  logic [15:0] exc_level;
  logic [1:0] sync_mode;
  logic sync_p = 0, hresp;
  int err_count = 0, comparisons = 0, cycles = 0, cnt;
  logic [7:0] modes [4] = '{8'h01, 8'h03, 8'h10, 8'h81};
  int incs [4] = '{512, 512, 4096, -512};

  always #4 clk = ~clk;

  src_top #(.SAMPLE_DIV(64)) src_top_inst (
    .I_CLK(clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HREADY(hreadyout), .I_HWDATA(hwdata),
    .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .I_SIN(sinv), .I_COS(cosv),
    .I_EXC_AT_MAX(exc_max), .I_EXC_AT_MIN(exc_min), .I_EXC_REF(exc_ref), .I_SYNC_PULSE(sync_p),
    .O_ADC_START(adc_start), .O_EXC_REF(exc_ref_o), .O_EXC_EN(exc_en), .O_EXC_LEVEL(exc_level),
    .O_SYNC_EN(sync_en), .O_SYNC_MODE(sync_mode), .O_IRQ(irq)
  );

  src_resolver_model src_resolver_model_inst (
    .i_clk(clk), .i_rstn(rstn), .i_adc_start(adc_start), .i_step(16'h1000), .i_amp(amp),
    .o_sin(sinv), .o_cos(cosv)
  );

  // ==========================================================================
  // Reporting
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic chk_near(input string name, input int exp, input int tol, input logic [31:0] got);
    int d;
    comparisons++;
    d = int'(got) - exp;
    if ($isunknown(got) || d > tol || d < -tol) begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %h", name, exp, got);
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      stop_test();
    end
  end

  // ==========================================================================
  // Bus access
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdata = hrdata;
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rdata);
  endtask

  task automatic rdn(input string n, input logic [7:0] a, input int e, input int tol);
    bus(1'b0, a, 32'h0);
    chk_near(n, e, tol, rdata);
  endtask

  // Waits for n conversion strobes, then until the results have landed.
  task automatic wait_upd(input int n);
    repeat (n) begin
      @(posedge clk);
      while (adc_start !== 1'b1) @(posedge clk);
    end
    repeat (25) @(posedge clk);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rdc("mode reset", `SRC_A_MODE, 32'h0);
    chk("bus response", 32'h0, {31'h0, hresp});
    rdc("low limit reset", `SRC_A_LOWLIM, 32'h2710);
    rdc("error code reset", `SRC_A_ERRC, 32'h0);
    rdc("mask reset", `SRC_A_MASK, 32'h0);
    rdc("pending reset", `SRC_A_PEND, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    bus(1'b1, `SRC_A_SHADJ, 32'h16a);
    rdc("phase adjust", `SRC_A_SHADJ, 32'hffffff6a);
    bus(1'b1, `SRC_A_SHADJ, 32'h100);
    bus(1'b1, `SRC_A_GAIN, 32'hfffff000);
    rdc("gain trim", `SRC_A_GAIN, 32'hfffff000);
    bus(1'b1, `SRC_A_GAIN, 32'h0);
    bus(1'b1, `SRC_A_EXCLVL, 32'h1234);
    @(posedge clk);
    chk("excitation level", 32'h1234, {16'h0, exc_level});
    bus(1'b1, `SRC_A_SYNC, 32'h7);
    @(posedge clk);
    chk("sync outputs", 32'h7, {29'h0, sync_mode, sync_en});
    bus(1'b1, `SRC_A_MASK, 32'hff);
    rdc("mask bits", `SRC_A_MASK, 32'h80);
    @(posedge clk);
    exc_ref <= 1'b1;
    @(posedge clk);
    chk("excitation ref early", 32'h0, {31'h0, exc_ref_o});
    repeat (5) @(posedge clk);
    chk("excitation ref", 32'h1, {31'h0, exc_ref_o});
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `SRC_A_MODE, 32'h0);
      repeat (4) @(posedge clk);
      rdc("position off", `SRC_A_POS, 32'h0);
      chk("excitation off", 32'h0, {31'h0, exc_en});
      bus(1'b1, `SRC_A_MODE, {24'h0, modes[i]});
      wait_upd(4);
      rdn("position", `SRC_A_POS, 3 * incs[i], 2);
      rdn("speed", `SRC_A_SPEED, incs[i], 2);
      chk("excitation on", 32'h1, {31'h0, exc_en});
    end
    bus(1'b1, `SRC_A_MODE, 32'h2);
    repeat (4) @(posedge clk);
    chk("unused mode", 32'h0, {31'h0, exc_en});
    bus(1'b1, `SRC_A_MODE, 32'h1);
    wait_upd(2);
    rdn("amplitude", `SRC_A_AMP, 16000, 300);
    @(posedge clk);
    while (adc_start !== 1'b1) @(posedge clk);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (adc_start !== 1'b1);
    chk("sample period", 32'd64, cnt);
    // A sync edge now restarts the grid: 3 sync stages, 64 counts, 2 to the strobe.
    sync_p <= 1'b1;
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (adc_start !== 1'b1);
    sync_p <= 1'b0;
    chk("sync realign", 32'd69, cnt);
    rdc("no event", `SRC_A_PEND, 32'h0);
    amp <= 16'd5000;
    wait_upd(2);
    rdc("low amp code", `SRC_A_ERRC, 32'h4);
    rdc("low amp pending", `SRC_A_PEND, 32'h80);
    rdc("low amp sign", `SRC_A_SIGN, 32'hffffffff);
    chk("irq raised", 32'h1, {31'h0, irq});
    amp <= 16'd16000;
    wait_upd(1);
    bus(1'b1, `SRC_A_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, `SRC_A_PEND, 32'h80);
    rdc("pending cleared", `SRC_A_PEND, 32'h0);
    rdc("code kept", `SRC_A_ERRC, 32'h4);
    bus(1'b1, `SRC_A_MASK, 32'h80);
    exc_max <= 1'b1;
    wait_upd(2);
    rdc("max code", `SRC_A_ERRC, 32'h1);
    rdc("max sign", `SRC_A_SIGN, 32'h1);
    chk("irq max", 32'h1, {31'h0, irq});
    exc_max <= 1'b0;
    exc_min <= 1'b1;
    wait_upd(2);
    rdc("min code", `SRC_A_ERRC, 32'h2);
    rdc("min sign", `SRC_A_SIGN, 32'hffffffff);
    exc_min <= 1'b0;
    wait_upd(1);
    bus(1'b1, `SRC_A_PEND, 32'h80);
    bus(1'b1, `SRC_A_ERRC, 32'h0);
    rdc("code cleared", `SRC_A_ERRC, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq idle", 32'h0, {31'h0, irq});
    stop_test();
  end
endmodule

// [dv/src_resolver_model.sv]
/*
  Behavioural resolver seen through its sine and cosine converters.
  Assumes the bench sets the angle step and the amplitude; the angle moves on
  after each conversion strobe, so the values stay still around the strobe.
*/
`timescale 1ns/1ps
module src_resolver_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_adc_start,
  input wire logic [15:0] i_step,
  input wire logic [15:0] i_amp,
  output logic [15:0] o_sin,
  output logic [15:0] o_cos
);
  logic [15:0] angle_r;
  real ph;
  // ==========================================================================
  // Shaft angle
  // The start angle sits clear of the zero crossing to keep truncation stable.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      angle_r <= 16'h0104;
    end else if (i_adc_start) begin
      angle_r <= angle_r + i_step;
    end
  end
  // ==========================================================================
  // Converter outputs
  always_comb begin
    ph = 6.283185307 * angle_r / 65536.0;
    o_sin = 16'($rtoi(i_amp * $sin(ph)));
    o_cos = 16'($rtoi(i_amp * $cos(ph)));
  end
endmodule

// [hdl/src_atan.sv]
/*
  Iterative vectoring rotator: angle of (x, y) as a 16-bit turn fraction and
  the vector length scaled by the rotator gain (about 1.647).
  Assumes a start pulse only while idle; o_done pulses 16 cycles later.
*/
`timescale 1ns/1ps
`include "src_consts.svh"
module src_atan import src_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire src_samp_t i_x,
  input wire src_samp_t i_y,
  output logic o_done,
  output logic [15:0] o_angle,
  output logic [19:0] o_mag
);
  logic signed [19:0] x_r;
  logic signed [19:0] y_r;
  logic [15:0] z_r;
  logic [3:0] it_r;
  logic busy_r;
  logic done_r;

  function automatic logic [15:0] atan_lut(input logic [3:0] i);
    case (i)
      4'h0: atan_lut = 16'h2000;
      4'h1: atan_lut = 16'h12e4;
      4'h2: atan_lut = 16'h09fb;
      4'h3: atan_lut = 16'h0511;
      4'h4: atan_lut = 16'h028b;
      4'h5: atan_lut = 16'h0146;
      4'h6: atan_lut = 16'h00a3;
      4'h7: atan_lut = 16'h0051;
      4'h8: atan_lut = 16'h0029;
      4'h9: atan_lut = 16'h0014;
      4'ha: atan_lut = 16'h000a;
      4'hb: atan_lut = 16'h0005;
      4'hc: atan_lut = 16'h0003;
      default: atan_lut = 16'h0001;
    endcase
  endfunction

  // Left half-plane vectors are turned by half a turn first.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      x_r <= 20'sh0;
      y_r <= 20'sh0;
      z_r <= 16'h0;
      it_r <= 4'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (i_start) begin
        x_r <= i_x[16] ? -20'(i_x) : 20'(i_x);
        y_r <= i_x[16] ? -20'(i_y) : 20'(i_y);
        z_r <= i_x[16] ? `SRC_HALF_TURN : 16'h0;
        it_r <= 4'h0;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (!y_r[19]) begin
          x_r <= x_r + (y_r >>> it_r);
          y_r <= y_r - (x_r >>> it_r);
          z_r <= z_r + atan_lut(it_r);
        end else begin
          x_r <= x_r - (y_r >>> it_r);
          y_r <= y_r + (x_r >>> it_r);
          z_r <= z_r - atan_lut(it_r);
        end
        it_r <= it_r + 4'h1;
        if (it_r == 4'he) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign o_done = done_r;
  assign o_angle = z_r;
  assign o_mag = x_r;
endmodule

// [hdl/src_consts.svh]
/*
  Constants of the second resolver channel: register byte offsets, reset
  values, field positions, error codes and timing counts.
  Assumes a 125 MHz system clock and a word-wide AHB-Lite register bus.
*/
// How it works
// R1 - Sample sine and cosine at fixed 4 kHz; the code samples at 4 kHz only for phase adjust -7 and below, 2 kHz at reset
// R2 - Angle is arctangent; speed, position follow
// R3 - Mode 0 disables channel, clears position
// R4 - Mode 1 runs normal standard resolver operation
// R5 - Mode 3 runs high-speed tracking
// R6 - High-speed mode tracks up to 32 MHz
// R7 - Mode 16 gives 65536 counts per turn
// R8 - Position absolute from angle at initialisation; the code loads position 0 on the first update instead
// R9 - Signed phase adjust covers plus/minus 150
// R10 - Sine gain trim before angle computation
// R11 - Amplitude below low limit raises error
// R12 - Last error reason readable by software
// R13 - Codes 0,1,2,4; overwritten, never self-cleared
// R14 - Mask bit 7 enables the monitoring interrupt
// R15 - Pending bit 7 flags the resolver error
// R16 - Sign of amplitude error kept readable
// R17 - External resolver gets primary excitation frequency
// R18 - Excitation amplitude from programmable level
// R19 - Synchronised clocks via sync flag, mode
// R20 - Interrupt only when pending and mask set
`ifndef SRC_CONSTS_SVH
`define SRC_CONSTS_SVH

`define SRC_CLK_HZ 125000000
`define SRC_SAMPLE_HZ 4000
`define SRC_SAMPLE_DIV (`SRC_CLK_HZ / `SRC_SAMPLE_HZ)
`define SRC_CLK_PS 8000
`define SRC_ADJ_UNIT_PS 1000000
`define SRC_US_DIV (`SRC_ADJ_UNIT_PS / `SRC_CLK_PS)

`define SRC_A_MODE 8'h00
`define SRC_A_SHADJ 8'h04
`define SRC_A_GAIN 8'h08
`define SRC_A_LOWLIM 8'h0c
`define SRC_A_ERRC 8'h10
`define SRC_A_POS 8'h14
`define SRC_A_SPEED 8'h18
`define SRC_A_ANGLE 8'h1c
`define SRC_A_AMP 8'h20
`define SRC_A_EXCLVL 8'h24
`define SRC_A_MASK 8'h28
`define SRC_A_PEND 8'h2c
`define SRC_A_SIGN 8'h30
`define SRC_A_SYNC 8'h34

`define SRC_RST_MODE 8'h00
`define SRC_RST_LOWLIM 15'h2710
`define SRC_EV_BIT 7
`define SRC_MODE_CCW 7
`define SRC_MODE_HR 4
`define SRC_MODE_UNUSED 7'h02

`define SRC_ERR_NONE 3'h0
`define SRC_ERR_EXCMAX 3'h1
`define SRC_ERR_EXCMIN 3'h2
`define SRC_ERR_LOWAMP 3'h4
`define SRC_SIGN_NEG 2'h3
`define SRC_SIGN_POS 2'h1
`define SRC_HALF_TURN 16'h8000

`endif

// [hdl/src_pkg.sv]
/*
  Types of the second resolver channel.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package src_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_CALC = 4'b0100,
    ST_UPD = 4'b1000
  } src_state_e;
  typedef logic signed [16:0] src_samp_t;
endpackage

// [hdl/src_top.sv]
/*
  Second resolver channel: AHB-Lite register slave, 4 kHz sample ticks with phase
  adjust (conversions at 4 kHz only for adjust -7 and below, 2 kHz at reset), gain trim,
  angle, speed and position tracking, amplitude and excitation monitoring with a
  maskable event, excitation and sync outputs.
  Assumes converter data and status pins are asynchronous and held stable
  around the conversion strobe; one 125 MHz clock.
*/
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`include "src_consts.svh"
module src_top import src_pkg::*; #(
  parameter int SAMPLE_DIV = `SRC_SAMPLE_DIV
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic I_HREADY,
  input wire logic [31:0] I_HWDATA,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic [15:0] I_SIN,
  input wire logic [15:0] I_COS,
  input wire logic I_EXC_AT_MAX,
  input wire logic I_EXC_AT_MIN,
  input wire logic I_EXC_REF,
  input wire logic I_SYNC_PULSE,
  output logic O_ADC_START,
  output logic O_EXC_REF,
  output logic O_EXC_EN,
  output logic [15:0] O_EXC_LEVEL,
  output logic O_SYNC_EN,
  output logic [1:0] O_SYNC_MODE,
  output logic O_IRQ
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN);
  // ==========================================================================
  // Pin synchronisers.
  logic [15:0] sin_s1_r, sin_s2_r, cos_s1_r, cos_s2_r;
  logic [3:0] pin_s1_r, pin_s2_r;
  logic sync_d_r, exc_ref_r;
  logic sync_edge;
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      {sin_s1_r, sin_s2_r, cos_s1_r, cos_s2_r, pin_s1_r, pin_s2_r, sync_d_r, exc_ref_r} <= 74'h0;
    end else begin
      {sin_s2_r, sin_s1_r} <= {sin_s1_r, I_SIN};
      {cos_s2_r, cos_s1_r} <= {cos_s1_r, I_COS};
      {pin_s2_r, pin_s1_r} <= {pin_s1_r, I_SYNC_PULSE, I_EXC_REF, I_EXC_AT_MIN, I_EXC_AT_MAX};
      sync_d_r <= pin_s2_r[3];
      exc_ref_r <= pin_s2_r[2]; // see R17
    end
  end
  assign sync_edge = pin_s2_r[3] & ~sync_d_r;
  assign O_EXC_REF = exc_ref_r;
  // ==========================================================================
  // Sample and microsecond timebases.
  logic [15:0] smp_cnt_r;
  logic [6:0] us_cnt_r;
  logic smp_tick, us_en, sync_restart;
  logic [2:0] sync_r;
  // With sync on, the other controller's pulse realigns the sample grid.
  assign sync_restart = sync_r[0] & sync_edge; // see R19
  assign smp_tick = smp_cnt_r == 16'(SAMPLE_DIV - 1); // see R1
  assign us_en = us_cnt_r == 7'(`SRC_US_DIV - 1);
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      smp_cnt_r <= 16'h0;
    end else if (sync_restart || smp_tick) begin
      smp_cnt_r <= 16'h0;
    end else begin
      smp_cnt_r <= smp_cnt_r + 16'h1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      us_cnt_r <= 7'h0;
    end else begin
      us_cnt_r <= us_en ? 7'h0 : us_cnt_r + 7'h1;
    end
  end

  // ==========================================================================
  // AHB-Lite slave: writes take no wait state, reads take one.
  logic dp_act_r, dp_wr_r, rd_ok_r, rd_wait, wr_en;
  logic [7:0] dp_addr_r;
  logic [31:0] hrdata_r, rd_mux;
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      {dp_act_r, dp_wr_r, dp_addr_r} <= 10'h0;
    end else if (I_HREADY) begin
      {dp_act_r, dp_wr_r, dp_addr_r} <= {I_HSEL & I_HTRANS[1], I_HWRITE, I_HADDR[7:0]};
    end
  end
  assign rd_wait = dp_act_r & ~dp_wr_r & ~rd_ok_r;
  assign wr_en = dp_act_r & dp_wr_r;
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rd_ok_r <= 1'b0;
      hrdata_r <= 32'h0;
    end else begin
      rd_ok_r <= rd_wait;
      if (rd_wait) begin
        hrdata_r <= rd_mux;
      end
    end
  end
  assign O_HRDATA = hrdata_r;
  assign O_HREADYOUT = ~rd_wait;
  assign O_HRESP = 1'b0;
  // ==========================================================================
  // Software registers.
  logic [7:0] mode_r;
  logic signed [8:0] shadj_r;
  logic signed [12:0] gain_r;
  logic [14:0] lowlim_r;
  logic [15:0] exc_lvl_r;
  logic mask_r;
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode_r <= `SRC_RST_MODE;
      shadj_r <= 9'sh0;
      gain_r <= 13'sh0;
      lowlim_r <= `SRC_RST_LOWLIM; // see R11
      exc_lvl_r <= 16'h0;
      mask_r <= 1'b0;
      sync_r <= 3'h0;
    end else if (wr_en) begin
      case (dp_addr_r)
        `SRC_A_MODE: mode_r <= I_HWDATA[7:0];
        `SRC_A_SHADJ: shadj_r <= I_HWDATA[8:0]; // see R9
        `SRC_A_GAIN: gain_r <= I_HWDATA[12:0]; // see R10
        `SRC_A_LOWLIM: lowlim_r <= I_HWDATA[14:0];
        `SRC_A_EXCLVL: exc_lvl_r <= I_HWDATA[15:0]; // see R18
        `SRC_A_MASK: mask_r <= I_HWDATA[`SRC_EV_BIT]; // see R14
        `SRC_A_SYNC: sync_r <= I_HWDATA[2:0]; // see R19
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Mode decode: mode 2 is unused and leaves the channel off.
  logic active, hs, hr, ccw;
  assign active = (mode_r[6:0] != 7'h0) && (mode_r[6:0] != `SRC_MODE_UNUSED); // see R3 R4
  assign hs = mode_r[1:0] == 2'b11; // see R5
  assign hr = mode_r[`SRC_MODE_HR]; // see R7
  assign ccw = mode_r[`SRC_MODE_CCW];
  assign O_EXC_EN = active;
  assign O_EXC_LEVEL = exc_lvl_r;
  assign O_SYNC_EN = sync_r[0];
  assign O_SYNC_MODE = sync_r[2:1];
  // ==========================================================================
  // Sample sequencer.
  src_state_e st_r;
  logic [8:0] dly_r;
  logic start_r, c_done;
  src_samp_t sin_g_r, cos_g_r, sin_g;
  logic signed [28:0] gprod;
  logic [15:0] c_ang;
  logic [19:0] c_mag;
  // Gain trim scales the sine path by 1 + gain/32768 (about 12.5 % per 4096).
  assign gprod = $signed(sin_s2_r) * gain_r;
  assign sin_g = 17'($signed(sin_s2_r)) + 17'(gprod >>> 15); // see R10
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r <= ST_IDLE;
      dly_r <= 9'h0;
      start_r <= 1'b0;
      sin_g_r <= 17'sh0;
      cos_g_r <= 17'sh0;
    end else begin
      start_r <= 1'b0;
      if (!active) begin
        st_r <= ST_IDLE;
      end else begin
        unique case (st_r)
          ST_IDLE: if (smp_tick) begin
            st_r <= ST_WAIT;
            // Flipping the sign bit gives adjust + 256 microseconds.
            dly_r <= {~shadj_r[8], shadj_r[7:0]}; // see R9
          end
          ST_WAIT: if (dly_r == 9'h0) begin
            st_r <= ST_CALC;
            start_r <= 1'b1;
            sin_g_r <= sin_g;
            cos_g_r <= 17'($signed(cos_s2_r));
          end else if (us_en) begin
            dly_r <= dly_r - 9'h1;
          end
          ST_CALC: if (c_done) begin
            st_r <= ST_UPD;
          end
          ST_UPD: st_r <= ST_IDLE;
        endcase
      end
    end
  end
  assign O_ADC_START = start_r;
  src_atan src_atan_inst (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_start(start_r),
    .i_x(cos_g_r),
    .i_y(sin_g_r),
    .o_done(c_done),
    .o_angle(c_ang),
    .o_mag(c_mag)
  );
  // ==========================================================================
  // Angle, speed and position tracking.
  logic [15:0] ang_r, ang_q, pred;
  logic signed [31:0] spd_r, spd_inc_r, pos_r, delta, inc, inc_dir;
  logic first_r;
  logic signed [15:0] d_raw, d_err;
  assign ang_q = hr ? c_ang : {c_ang[15:3], 3'b000}; // see R7
  assign pred = ang_r + spd_r[15:0];
  assign d_raw = $signed(ang_q - ang_r); // see R2
  // High speed predicts from the last step, so only the error must wrap.
  assign d_err = $signed(ang_q - pred); // see R5 R6
  assign delta = hs ? spd_r + 32'(d_err) : 32'(d_raw);
  assign inc = hr ? delta : delta >>> 3;
  assign inc_dir = ccw ? -inc : inc;
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ang_r <= 16'h0;
      spd_r <= 32'sh0;
      spd_inc_r <= 32'sh0;
      pos_r <= 32'sh0;
      first_r <= 1'b1;
    end else if (!active) begin
      spd_r <= 32'sh0;
      spd_inc_r <= 32'sh0;
      pos_r <= 32'sh0; // see R3
      first_r <= 1'b1;
    end else if (st_r == ST_UPD) begin
      ang_r <= ang_q;
      first_r <= 1'b0;
      if (first_r) begin
        pos_r <= 32'sh0; // see R8
      end else begin
        spd_r <= delta;
        spd_inc_r <= inc_dir;
        pos_r <= pos_r + inc_dir; // see R2
      end
    end
  end

  // ==========================================================================
  // Amplitude and excitation monitoring.
  logic [19:0] amp_full;
  logic [15:0] amp_r;
  logic [2:0] errc_r, ev_code;
  logic [1:0] sign_r;
  logic pend_r, irq_r, ev;
  // Removes the rotator gain: 1/2 + 1/8 - 1/64 is about 1/1.647.
  assign amp_full = (c_mag >> 1) + (c_mag >> 3) - (c_mag >> 6);
  always_comb begin
    ev_code = `SRC_ERR_NONE;
    if (amp_full < 20'(lowlim_r)) begin
      ev_code = `SRC_ERR_LOWAMP; // see R11 R13
    end else if (pin_s2_r[0]) begin
      ev_code = `SRC_ERR_EXCMAX;
    end else if (pin_s2_r[1]) begin
      ev_code = `SRC_ERR_EXCMIN;
    end
  end
  assign ev = (st_r == ST_UPD) && active && (ev_code != `SRC_ERR_NONE);
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      amp_r <= 16'h0;
    end else if (st_r == ST_UPD) begin
      amp_r <= amp_full[15:0];
    end
  end
  // A hardware event wins over a software write in the same cycle.
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      errc_r <= `SRC_ERR_NONE;
      sign_r <= 2'h0;
    end else if (ev) begin
      errc_r <= ev_code; // see R12 R13
      sign_r <= (ev_code == `SRC_ERR_EXCMAX) ? `SRC_SIGN_POS : `SRC_SIGN_NEG; // see R16
    end else if (wr_en && dp_addr_r == `SRC_A_ERRC) begin
      errc_r <= I_HWDATA[2:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pend_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      if (ev) begin
        pend_r <= 1'b1; // see R15
      end else if (wr_en && dp_addr_r == `SRC_A_PEND && I_HWDATA[`SRC_EV_BIT]) begin
        pend_r <= 1'b0;
      end
      irq_r <= pend_r & mask_r; // see R14 R20
    end
  end
  assign O_IRQ = irq_r;
  // ==========================================================================
  // Read multiplexer.
  always_comb begin
    rd_mux = 32'h0;
    case (dp_addr_r)
      `SRC_A_MODE: rd_mux = {24'h0, mode_r};
      `SRC_A_SHADJ: rd_mux = 32'(shadj_r);
      `SRC_A_GAIN: rd_mux = 32'(gain_r);
      `SRC_A_LOWLIM: rd_mux = {17'h0, lowlim_r};
      `SRC_A_ERRC: rd_mux = {29'h0, errc_r};
      `SRC_A_POS: rd_mux = pos_r;
      `SRC_A_SPEED: rd_mux = spd_inc_r;
      `SRC_A_ANGLE: rd_mux = {16'h0, ang_r};
      `SRC_A_AMP: rd_mux = {16'h0, amp_r};
      `SRC_A_EXCLVL: rd_mux = {16'h0, exc_lvl_r};
      `SRC_A_MASK: rd_mux = {24'h0, mask_r, 7'h0};
      `SRC_A_PEND: rd_mux = {24'h0, pend_r, 7'h0};
      `SRC_A_SIGN: rd_mux = 32'($signed(sign_r));
      `SRC_A_SYNC: rd_mux = {29'h0, sync_r};
      default: rd_mux = 32'h0;
    endcase
  end

  // ==========================================================================
  // Checks.
  logic [15:0] gap_r;
  logic seen_r;
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      gap_r <= 16'h0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= (smp_tick || sync_restart) ? 16'h0 : gap_r + 16'h1;
      seen_r <= seen_r | smp_tick;
    end
  end
  sequence s_start;
    O_ADC_START && active;
  endsequence
  sequence s_update;
    ##[1:20] (st_r == ST_UPD);
  endsequence
  tick_period_a: assert property (smp_tick && seen_r |-> gap_r == 16'(SAMPLE_DIV - 1)) // see R1
    else $error("sample ticks not evenly spaced");
  calc_done_a: assert property (s_start |-> s_update) // see R2
    else $error("sample not converted to angle in time");
  mode_off_a: assert property (!active |-> O_EXC_EN == 1'b0 ##1 pos_r == 32'sh0) // see R3
    else $error("inactive channel kept a position");
  first_zero_a: assert property (st_r == ST_UPD && active && first_r |=> // see R8
    pos_r == 32'sh0 && ang_r == $past(ang_q))
    else $error("position not referenced at initialisation");
  low_amp_a: assert property (ev && ev_code == `SRC_ERR_LOWAMP |=> // see R11
    errc_r == `SRC_ERR_LOWAMP && pend_r && sign_r == `SRC_SIGN_NEG)
    else $error("low amplitude not reported");
  pend_sticky_a: assert property (pend_r && !(wr_en && dp_addr_r == `SRC_A_PEND) |=> pend_r) // see R15
    else $error("pending bit dropped without a clear");
  irq_gate_a: assert property (O_IRQ |-> $past(pend_r) && $past(mask_r)) // see R20
    else $error("interrupt without pending and mask");
  err_keep_a: assert property (!ev && !wr_en |=> $stable(errc_r)) // see R13
    else $error("error code changed by itself");
endmodule
